// ---- socket_aux_consts.svh ----
// constants for the socket auxiliary audio and control block
`ifndef SOCKET_AUX_CONSTS_SVH
`define SOCKET_AUX_CONSTS_SVH
// ----------------------------------------------------------------
// register byte addresses (word aligned)
// ----------------------------------------------------------------
`define ADDR_SOCK0_CTRL 8'h10
`define ADDR_SOCK1_CTRL 8'h14
`define ADDR_SOCK0_PRES 8'h08
`define ADDR_SOCK1_PRES 8'h18
`define ADDR_SOCK0_FORCE 8'h0C
`define ADDR_SOCK1_FORCE 8'h1C
`define ADDR_SYS_CTRL 8'h80
`define ADDR_CARD0_CTRL 8'h90
`define ADDR_CARD1_CTRL 8'h94
`define ADDR_STATUS 8'hA0
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_VIDEO_ENABLE 9
`define BIT_STD_MODEL 10
`define BIT_VIDEO_IN_USE 11
`define BIT_VIDEO_SUPPORTED 27
`define BIT_FORCE_SUPPORT 27
`define BIT_INT_CLK_SEL 27
`define BIT_CARD_SPEAKER_IN_EN 1
`define BIT_PWM_ROUTE 2
`define BIT_IO_MODE 0
`define BIT_PWM_TERM_SEL 4
// ----------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------
`define CLK_SYS_HZ 25000000
`define RING_OSC_HZ 16000
`define RING_HALF_CYCLES (`CLK_SYS_HZ / (2 * `RING_OSC_HZ))
`define ZERO_WORD 32'h0000_0000
`define ZERO_BYTE 8'h00
`endif

// ---- socket_aux_pkg.sv ----
// types for the socket auxiliary audio and control block
package socket_aux_pkg;
  typedef enum logic [1:0] {
    CARD_NONE = 2'b00,
    CARD_16BIT = 2'b01,
    CARD_CARDBUS = 2'b10
  } card_type_e;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_e;
endpackage

// ---- ring_osc_div.sv ----
// divider standing in for the internal low-frequency oscillator
`timescale 1ns/10ps
`include "socket_aux_consts.svh"
module ring_osc_div #(
  parameter int HALF_CYCLES = `RING_HALF_CYCLES
) (
  input wire logic clk, // system clock
  input wire logic srst, // synchronous reset
  input wire logic run, // oscillator enable
  output logic osc // slow clock output
);
  typedef struct packed {
    logic [15:0] count;
    logic osc;
  } osc_s;
  osc_s r;
  osc_s next_r;
  initial begin
    if (HALF_CYCLES < 1 || HALF_CYCLES > 65535) begin
      $error("ring_osc_div: HALF_CYCLES out of range");
    end
  end
  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // stops and parks low while disabled, so nothing toggles after reset
  always_comb begin
    next_r = r;
    if (!run) begin
      next_r.count = 16'h0000;
      next_r.osc = 1'b0;
    end else if (r.count == 16'(HALF_CYCLES - 1)) begin
      next_r.count = 16'h0000;
      next_r.osc = ~r.osc;
    end else begin
      next_r.count = r.count + 16'h0001;
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  assign osc = r.osc;
endmodule

// ---- socket_aux_audio_control.sv ----
// socket auxiliary control: video flags, oscillator, pulls and audio
// ----------------------------------------------------------------
// Notes on behaviour
// - socket control bit 10 reports standard model
// - internal 16 kHz oscillator drives INTERNAL_OSC
// - oscillator off after reset, runs on bit 27
// - pullup for 16-bit, pulldown for CardBus
// - I/O mode 16-bit: second detect is speaker
// - speaker output is XOR of both sockets
// - speaker output driven only when enabled
// - route bit sends CardBus audio to PWM out
// - both routed: socket 0 wins
// - PWM audio available on multifunction terminal
// - in-use bit set when either socket enabled
// - per-socket video enable at bit 9
// - force bit 27 sets supported flag
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "socket_aux_consts.svh"
module socket_aux_audio_control
  import socket_aux_pkg::*;
#(
  parameter logic STD_MODEL = 1'b1, // standard video model present
  parameter int OSC_HALF = `RING_HALF_CYCLES // oscillator half period
) (
  input wire logic CLK_SYS, // 25 MHz system clock
  input wire logic SRST, // synchronous reset, active high
  input wire logic WB_CYC_I, // wishbone cycle
  input wire logic WB_STB_I, // wishbone strobe
  input wire logic WB_WE_I, // wishbone write enable
  input wire logic [7:0] WB_ADR_I, // wishbone byte address
  input wire logic [3:0] WB_SEL_I, // wishbone byte selects
  input wire logic [31:0] WB_DAT_I, // wishbone write data
  output logic [31:0] WB_DAT_O, // wishbone read data
  output logic WB_ACK_O, // wishbone acknowledge
  input wire logic [1:0] CARD0_TYPE, // socket 0 card type
  input wire logic [1:0] CARD1_TYPE, // socket 1 card type
  input wire logic BATTERY_DETECT_TWO_0, // socket 0 second detect
  input wire logic BATTERY_DETECT_TWO_1, // socket 1 second detect
  output logic STATUS_CHANGE_PU_0, // socket 0 pullup enable
  output logic STATUS_CHANGE_PD_0, // socket 0 pulldown enable
  output logic STATUS_CHANGE_PU_1, // socket 1 pullup enable
  output logic STATUS_CHANGE_PD_1, // socket 1 pulldown enable
  output logic COMBINED_SPEAKER_OUT, // xor of binary audio
  output logic COMBINED_SPEAKER_OE, // speaker pin output enable
  output logic MULTIFUNCTION_TERMINAL, // carries pwm audio out
  output logic MULTIFUNCTION_OE, // multifunction pin enable
  output logic VIDEO_ENABLE_0, // socket 0 zoomed video on
  output logic VIDEO_ENABLE_1, // socket 1 zoomed video on
  output logic INTERNAL_OSC // internal slow clock
);
  typedef struct packed {
    logic [1:0] video_port_enable;
    logic [1:0] video_port_supported;
    logic internal_clock_select;
    logic [1:0] speaker_output_enable;
    logic [1:0] pwm_audio_route;
    logic [1:0] io_mode;
    logic pwm_terminal_select;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] pu;
    logic [1:0] pd;
    logic spk;
    logic spk_oe;
    logic pwm;
    logic pwm_oe;
    logic osc;
  } state_s;
  state_s r;
  state_s next_r;
  logic osc_raw;
  logic [1:0] card_spk;
  logic [1:0] cb_audio;
  logic [1:0] is16;
  logic [1:0] iscb;
  logic wr;
  logic rd;
  logic in_use;
  logic [31:0] rmux;
  initial begin
    if (OSC_HALF < 1) begin
      $error("socket_aux_audio_control: OSC_HALF must be positive");
    end
  end
  // ----------------------------------------------------------------
  // internal oscillator
  // ----------------------------------------------------------------
  ring_osc_div #(
    .HALF_CYCLES(OSC_HALF)
  ) u_osc (
    .clk(CLK_SYS),
    .srst(SRST),
    .run(r.internal_clock_select),
    .osc(osc_raw)
  );
  // ----------------------------------------------------------------
  // per-socket card decode
  // ----------------------------------------------------------------
  // socket bits are the same logic twice, so one loop
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sock
      logic [1:0] ctype;
      logic battery_detect_two;
      assign ctype = (g == 0) ? CARD0_TYPE : CARD1_TYPE;
      assign battery_detect_two = (g == 0) ? BATTERY_DETECT_TWO_0 : BATTERY_DETECT_TWO_1;
      assign is16[g] = (ctype == CARD_16BIT);
      assign iscb[g] = (ctype == CARD_CARDBUS);
      // speaker input only in 16-bit I/O mode or CardBus binary audio
      assign card_spk[g] = battery_detect_two & ((is16[g] & r.io_mode[g]) | iscb[g]);
      assign cb_audio[g] = battery_detect_two & iscb[g];
    end
  endgenerate
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // the ack register gives a one-cycle gap so each access acks once
  assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~r.ack;
  assign rd = WB_CYC_I & WB_STB_I & ~WB_WE_I & ~r.ack;
  assign in_use = |r.video_port_enable;
  // read mux of live state
  always_comb begin
    rmux = `ZERO_WORD;
    case (WB_ADR_I)
      `ADDR_SOCK0_CTRL, `ADDR_SOCK1_CTRL: begin
        rmux[`BIT_VIDEO_ENABLE] = (WB_ADR_I == `ADDR_SOCK0_CTRL) ?
          r.video_port_enable[0] : r.video_port_enable[1];
        rmux[`BIT_STD_MODEL] = STD_MODEL;
        rmux[`BIT_VIDEO_IN_USE] = in_use;
      end
      `ADDR_SOCK0_PRES: begin
        rmux[`BIT_VIDEO_SUPPORTED] = r.video_port_supported[0];
      end
      `ADDR_SOCK1_PRES: begin
        rmux[`BIT_VIDEO_SUPPORTED] = r.video_port_supported[1];
      end
      `ADDR_SYS_CTRL: begin
        rmux[`BIT_INT_CLK_SEL] = r.internal_clock_select;
      end
      `ADDR_CARD0_CTRL: begin
        rmux[`BIT_IO_MODE] = r.io_mode[0];
        rmux[`BIT_CARD_SPEAKER_IN_EN] = r.speaker_output_enable[0];
        rmux[`BIT_PWM_ROUTE] = r.pwm_audio_route[0];
      end
      `ADDR_CARD1_CTRL: begin
        rmux[`BIT_IO_MODE] = r.io_mode[1];
        rmux[`BIT_CARD_SPEAKER_IN_EN] = r.speaker_output_enable[1];
        rmux[`BIT_PWM_ROUTE] = r.pwm_audio_route[1];
      end
      `ADDR_STATUS: begin
        rmux[1:0] = is16;
        rmux[3:2] = iscb;
        rmux[`BIT_PWM_TERM_SEL] = r.pwm_terminal_select;
      end
      default: begin
        rmux = `ZERO_WORD;
      end
    endcase
  end
  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.ack = (wr | rd);
    next_r.rdata = rd ? rmux : `ZERO_WORD;
    if (wr) begin
      case (WB_ADR_I)
        `ADDR_SOCK0_CTRL: begin
          if (WB_SEL_I[1]) begin
            next_r.video_port_enable[0] = WB_DAT_I[`BIT_VIDEO_ENABLE];
          end
        end
        `ADDR_SOCK1_CTRL: begin
          if (WB_SEL_I[1]) begin
            next_r.video_port_enable[1] = WB_DAT_I[`BIT_VIDEO_ENABLE];
          end
        end
        `ADDR_SOCK0_FORCE: begin
          // force only sets; reset is the only clear
          if (WB_SEL_I[3] && WB_DAT_I[`BIT_FORCE_SUPPORT]) begin
            next_r.video_port_supported[0] = 1'b1;
          end
        end
        `ADDR_SOCK1_FORCE: begin
          if (WB_SEL_I[3] && WB_DAT_I[`BIT_FORCE_SUPPORT]) begin
            next_r.video_port_supported[1] = 1'b1;
          end
        end
        `ADDR_SYS_CTRL: begin
          if (WB_SEL_I[3]) begin
            next_r.internal_clock_select = WB_DAT_I[`BIT_INT_CLK_SEL];
          end
        end
        `ADDR_CARD0_CTRL: begin
          if (WB_SEL_I[0]) begin
            next_r.io_mode[0] = WB_DAT_I[`BIT_IO_MODE];
            next_r.speaker_output_enable[0] = WB_DAT_I[`BIT_CARD_SPEAKER_IN_EN];
            next_r.pwm_audio_route[0] = WB_DAT_I[`BIT_PWM_ROUTE];
          end
        end
        `ADDR_CARD1_CTRL: begin
          if (WB_SEL_I[0]) begin
            next_r.io_mode[1] = WB_DAT_I[`BIT_IO_MODE];
            next_r.speaker_output_enable[1] = WB_DAT_I[`BIT_CARD_SPEAKER_IN_EN];
            next_r.pwm_audio_route[1] = WB_DAT_I[`BIT_PWM_ROUTE];
          end
        end
        `ADDR_STATUS: begin
          if (WB_SEL_I[0]) begin
            next_r.pwm_terminal_select = WB_DAT_I[`BIT_PWM_TERM_SEL];
          end
        end
        default: begin
          next_r.ack = 1'b1;
        end
      endcase
    end
    // pull direction follows card type, none when empty
    next_r.pu = is16;
    next_r.pd = iscb;
    // either socket's enable bit turns the shared speaker on
    next_r.spk_oe = |r.speaker_output_enable;
    next_r.spk = (^card_spk) & (|r.speaker_output_enable);
    // socket 0 has priority when both route pwm audio
    if (r.pwm_audio_route[0]) begin
      next_r.pwm = cb_audio[0];
    end else if (r.pwm_audio_route[1]) begin
      next_r.pwm = cb_audio[1];
    end else begin
      next_r.pwm = 1'b0;
    end
    next_r.pwm_oe = r.pwm_terminal_select;
    next_r.osc = osc_raw;
  end
  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
  // outputs straight from flops
  assign WB_DAT_O = r.rdata;
  assign WB_ACK_O = r.ack;
  assign STATUS_CHANGE_PU_0 = r.pu[0];
  assign STATUS_CHANGE_PD_0 = r.pd[0];
  assign STATUS_CHANGE_PU_1 = r.pu[1];
  assign STATUS_CHANGE_PD_1 = r.pd[1];
  assign COMBINED_SPEAKER_OUT = r.spk;
  assign COMBINED_SPEAKER_OE = r.spk_oe;
  assign MULTIFUNCTION_TERMINAL = r.pwm;
  assign MULTIFUNCTION_OE = r.pwm_oe;
  assign VIDEO_ENABLE_0 = r.video_port_enable[0];
  assign VIDEO_ENABLE_1 = r.video_port_enable[1];
  assign INTERNAL_OSC = r.osc;
endmodule

// ---- card_pair_model.sv ----
// two card sockets: card kind and the second detect audio lines
`timescale 1ns/10ps
module card_pair_model
  import socket_aux_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic [1:0] kind0, // card wanted in socket 0
  input wire logic [1:0] kind1, // card wanted in socket 1
  output logic [1:0] type0, // socket 0 card type
  output logic [1:0] type1, // socket 1 card type
  output logic line0, // socket 0 audio line
  output logic line1 // socket 1 audio line
);
  // ----------------------------------------------------------------
  // audio patterns
  // ----------------------------------------------------------------
  logic [2:0] phase;
  initial begin
    phase = 3'h0;
    type0 = CARD_NONE;
    type1 = CARD_NONE;
    line0 = 1'h1;
    line1 = 1'h1;
  end
  // an empty socket floats to the pullup level, so gating must hold
  always @(posedge clk) begin
    phase <= phase + 3'h1;
    type0 <= kind0;
    type1 <= kind1;
    line0 <= (kind0 == CARD_NONE) ? 1'h1 : phase[1];
    line1 <= (kind1 == CARD_NONE) ? 1'h1 : phase[0] ^ phase[2];
  end
endmodule

// ---- socket_aux_chk.sv ----
// assertions on the socket auxiliary control block ports
`timescale 1ns/10ps
module socket_aux_chk
  import socket_aux_pkg::*;
#(
  parameter logic STD_MODEL = 1'h1,
  parameter int OSC_HALF = 781
) (
  input wire logic CLK_SYS, // clock
  input wire logic SRST, // reset
  input wire logic WB_CYC_I, // cycle
  input wire logic WB_STB_I, // strobe
  input wire logic WB_WE_I, // write
  input wire logic [7:0] WB_ADR_I, // address
  input wire logic [3:0] WB_SEL_I, // lanes
  input wire logic [31:0] WB_DAT_I, // write data
  input wire logic [31:0] WB_DAT_O, // read data
  input wire logic WB_ACK_O, // ack
  input wire logic [1:0] CARD0_TYPE, // type 0
  input wire logic [1:0] CARD1_TYPE, // type 1
  input wire logic BATTERY_DETECT_TWO_0, // audio 0
  input wire logic BATTERY_DETECT_TWO_1, // audio 1
  input wire logic STATUS_CHANGE_PU_0, // pullup 0
  input wire logic STATUS_CHANGE_PD_0, // pulldown 0
  input wire logic STATUS_CHANGE_PU_1, // pullup 1
  input wire logic STATUS_CHANGE_PD_1, // pulldown 1
  input wire logic COMBINED_SPEAKER_OUT, // speaker
  input wire logic COMBINED_SPEAKER_OE, // speaker enable
  input wire logic MULTIFUNCTION_TERMINAL, // pwm audio
  input wire logic MULTIFUNCTION_OE, // pwm enable
  input wire logic VIDEO_ENABLE_0, // video 0
  input wire logic VIDEO_ENABLE_1, // video 1
  input wire logic INTERNAL_OSC // slow clock
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  logic take;
  logic osel;
  logic mfs;
  logic osc_q;
  logic [2:0] cc0;
  logic [2:0] cc1;
  int stay;
  assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // shadow control bits, written at the edge a request is taken
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      osel <= 1'h0;
      mfs <= 1'h0;
      cc0 <= 3'h0;
      cc1 <= 3'h0;
    end else if (take && WB_WE_I) begin
      if (WB_ADR_I == 8'h80 && WB_SEL_I[3]) osel <= WB_DAT_I[27];
      if (WB_ADR_I == 8'hA0 && WB_SEL_I[0]) mfs <= WB_DAT_I[4];
      if (WB_ADR_I == 8'h90 && WB_SEL_I[0]) cc0 <= WB_DAT_I[2:0];
      if (WB_ADR_I == 8'h94 && WB_SEL_I[0]) cc1 <= WB_DAT_I[2:0];
    end
  end
  // cycles the slow clock has held its level while enabled
  always_ff @(posedge CLK_SYS) begin
    osc_q <= INTERNAL_OSC;
    if (!osel || INTERNAL_OSC != osc_q) stay <= 0;
    else stay <= stay + 1;
  end
  sequence rd_ctrl0;
    take && !WB_WE_I && WB_ADR_I == 8'h10;
  endsequence
  sequence rd_ctrl;
    take && !WB_WE_I && (WB_ADR_I == 8'h10 || WB_ADR_I == 8'h14);
  endsequence
  sequence cb_pair;
    !SRST && CARD0_TYPE == CARD_CARDBUS && CARD1_TYPE == CARD_CARDBUS;
  endsequence
  sequence io16_0;
    !SRST && CARD0_TYPE == CARD_16BIT && cc0[0] && CARD1_TYPE == CARD_NONE;
  endsequence
  std_flag_a: assert property (
    rd_ctrl0 |=> WB_ACK_O && WB_DAT_O[10] == STD_MODEL)
    else $error("standard model flag wrong");
  video_bit_a: assert property (
    rd_ctrl0 |=> WB_DAT_O[9] == VIDEO_ENABLE_0)
    else $error("video enable readback wrong");
  in_use_a: assert property (
    rd_ctrl |=> WB_DAT_O[11] == (VIDEO_ENABLE_0 || VIDEO_ENABLE_1))
    else $error("video in use flag wrong");
  osc_period_a: assert property (stay <= OSC_HALF + 3)
    else $error("slow clock stalled");
  osc_off_a: assert property (!osel [*4] |-> !INTERNAL_OSC)
    else $error("slow clock runs while off");
  pull_dir_a: assert property (
    !$past(SRST) |-> {STATUS_CHANGE_PU_0, STATUS_CHANGE_PD_0,
    STATUS_CHANGE_PU_1, STATUS_CHANGE_PD_1} ==
    {$past(CARD0_TYPE) == CARD_16BIT, $past(CARD0_TYPE) == CARD_CARDBUS,
    $past(CARD1_TYPE) == CARD_16BIT, $past(CARD1_TYPE) == CARD_CARDBUS})
    else $error("pull direction wrong");
  // the shared speaker is gated by either socket's enable bit
  io_speaker_a: assert property (
    io16_0 |=> COMBINED_SPEAKER_OUT ==
    $past(BATTERY_DETECT_TWO_0 && (cc0[1] || cc1[1])))
    else $error("io mode speaker wrong");
  spk_xor_a: assert property (
    cb_pair |=> COMBINED_SPEAKER_OUT == $past((BATTERY_DETECT_TWO_0 ^
    BATTERY_DETECT_TWO_1) && (cc0[1] || cc1[1])))
    else $error("speaker xor wrong");
  spk_enable_a: assert property (
    !$past(SRST) |-> COMBINED_SPEAKER_OE == $past(cc0[1] || cc1[1]))
    else $error("speaker enable wrong");
  pwm_route_a: assert property (
    cb_pair ##0 (cc1[2] && !cc0[2]) |=>
    MULTIFUNCTION_TERMINAL == $past(BATTERY_DETECT_TWO_1))
    else $error("pwm route wrong");
  pwm_prio_a: assert property (
    cb_pair ##0 cc0[2] |=>
    MULTIFUNCTION_TERMINAL == $past(BATTERY_DETECT_TWO_0))
    else $error("pwm priority wrong");
  pwm_pin_a: assert property (
    !$past(SRST) |-> MULTIFUNCTION_OE == $past(mfs))
    else $error("pwm terminal enable wrong");
endmodule
bind socket_aux_audio_control socket_aux_chk
  #(.STD_MODEL(STD_MODEL), .OSC_HALF(OSC_HALF)) chk (.*);

// ---- test_socket_aux_audio_control.sv ----
// self-checking bench for the socket auxiliary control block
`timescale 1ns/10ps
module test_socket_aux_audio_control
  import socket_aux_pkg::*;
;
  typedef struct packed {
    logic [1:0] k0;
    logic [1:0] k1;
    logic [2:0] c0;
    logic [2:0] c1;
    logic [3:0] pull;
    logic oe;
    logic [1:0] spk;
    logic [1:0] pwm;
  } row_s;
  // pull is {pu0, pd0, pu1, pd1}; spk masks sockets; pwm bit per socket
  row_s rows [6] = '{
    '{CARD_NONE, CARD_NONE, 3'h0, 3'h0, 4'h0, 1'h0, 2'h0, 2'h0},
    '{CARD_16BIT, CARD_16BIT, 3'h3, 3'h0, 4'hA, 1'h1, 2'h1, 2'h0},
    '{CARD_CARDBUS, CARD_CARDBUS, 3'h0, 3'h2, 4'h5, 1'h1, 2'h3, 2'h0},
    '{CARD_CARDBUS, CARD_CARDBUS, 3'h4, 3'h4, 4'h5, 1'h0, 2'h3, 2'h1},
    '{CARD_CARDBUS, CARD_CARDBUS, 3'h0, 3'h6, 4'h5, 1'h1, 2'h3, 2'h2},
    '{CARD_16BIT, CARD_NONE, 3'h3, 3'h0, 4'h8, 1'h1, 2'h1, 2'h0}
  };
  logic clk, srst, cyc, stb, we, ack, b0, b1, p0, p1, last;
  logic pu0, pd0, pu1, pd1, spk, spk_oe, mf, mf_oe, ve0, ve1, osc;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [1:0] k0, k1, t0, t1;
  int failures, comparisons, n;
  row_s r;
  socket_aux_audio_control #(.STD_MODEL(1'h1), .OSC_HALF(4)) dut (
    .CLK_SYS(clk), .SRST(srst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .CARD0_TYPE(t0), .CARD1_TYPE(t1),
    .BATTERY_DETECT_TWO_0(b0), .BATTERY_DETECT_TWO_1(b1),
    .STATUS_CHANGE_PU_0(pu0), .STATUS_CHANGE_PD_0(pd0),
    .STATUS_CHANGE_PU_1(pu1), .STATUS_CHANGE_PD_1(pd1),
    .COMBINED_SPEAKER_OUT(spk), .COMBINED_SPEAKER_OE(spk_oe),
    .MULTIFUNCTION_TERMINAL(mf), .MULTIFUNCTION_OE(mf_oe),
    .VIDEO_ENABLE_0(ve0), .VIDEO_ENABLE_1(ve1), .INTERNAL_OSC(osc));
  card_pair_model cards (.clk(clk), .kind0(k0), .kind1(k1), .type0(t0),
    .type1(t1), .line0(b0), .line1(b1));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one classic cycle, entered just after a rising edge
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    q = rdat;
    if (t == 20) begin
      failures++;
      conclude();
    end
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask
  // driver software turning on zoomed video for a fresh card
  task sw_zv(input logic s);
    logic [31:0] c;
    wb(1'h0, s ? 8'h14 : 8'h10, 4'hF, 32'h0);
    c = q;
    wb(1'h0, s ? 8'h18 : 8'h08, 4'hF, 32'h0);
    if (c[10] !== 1'h1) $display("legacy video path");
    else if (q[27] !== 1'h1) $display("try the other socket");
    else if (c[11] === 1'h1) $display("video port occupied");
    else wb(1'h1, s ? 8'h14 : 8'h10, 4'h2, c | 32'h0000_0200);
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // watchdog well past the expected run of a few hundred cycles
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    {srst, cyc, stb, we, adr, sel, wdat} = {1'h1, 47'h0};
    k0 = CARD_NONE;
    k1 = CARD_NONE;
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    wb(1'h1, 8'hA0, 4'h1, 32'h0000_0010);
    foreach (rows[i]) begin
      r = rows[i];
      k0 <= r.k0;
      k1 <= r.k1;
      wb(1'h1, 8'h90, 4'h1, 32'(r.c0));
      wb(1'h1, 8'h94, 4'h1, 32'(r.c1));
      repeat (3) @(posedge clk);
      @(negedge clk);
      p0 = b0;
      p1 = b1;
      @(negedge clk);
      check(32'({pu0, pd0, pu1, pd1}), 32'(r.pull));
      check(32'(spk_oe), 32'(r.oe));
      check(32'(spk), 32'(r.oe & (r.spk[0] & p0 ^ r.spk[1] & p1)));
      check(32'(mf), 32'(r.pwm[0] ? p0 : r.pwm[1] & p1));
      check(32'(mf_oe), 32'h1);
      @(posedge clk);
      $display("row %0d done", i);
    end
    sw_zv(1'h0);
    check(32'(ve0), 32'h0);
    wb(1'h1, 8'h0C, 4'h8, 32'h0800_0000);
    wb(1'h0, 8'h08, 4'hF, 32'h0);
    check(q, 32'h0800_0000);
    sw_zv(1'h0);
    check(32'(ve0), 32'h1);
    wb(1'h1, 8'h1C, 4'h8, 32'h0800_0000);
    sw_zv(1'h1);
    check(32'(ve1), 32'h0);
    wb(1'h0, 8'h14, 4'hF, 32'h0);
    check(q, 32'h0000_0C00);
    wb(1'h1, 8'h10, 4'hD, 32'h0);
    check(32'(ve0), 32'h1);
    wb(1'h1, 8'h10, 4'h2, 32'h0);
    wb(1'h0, 8'h10, 4'hF, 32'h0);
    check(q, 32'h0000_0400);
    wb(1'h1, 8'h40, 4'hF, 32'hFFFF_FFFF);
    wb(1'h0, 8'h40, 4'hF, 32'h0);
    check(q, 32'h0);
    $display("video test done");
    check(32'(osc), 32'h0);
    wb(1'h1, 8'h80, 4'h8, 32'h0800_0000);
    n = 0;
    last = osc;
    repeat (80) begin
      @(posedge clk);
      if (osc !== last) n++;
      last = osc;
    end
    check(32'(n >= 18 && n <= 20), 32'h1);
    wb(1'h1, 8'h80, 4'h8, 32'h0);
    repeat (4) @(posedge clk);
    check(32'(osc), 32'h0);
    $display("oscillator test done");
    srst <= 1'h1;
    repeat (2) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    check(32'({ve0, ve1, spk_oe, mf_oe, osc}), 32'h0);
    @(posedge clk);
    wb(1'h0, 8'h08, 4'hF, 32'h0);
    check(q, 32'h0);
    wb(1'h0, 8'h10, 4'hF, 32'h0);
    check(q, 32'h0000_0400);
    $display("reset test done");
    conclude();
  end
endmodule
